// >>> shared/tgc_pkg.sv
package tgc_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] TGC_OFS_MAIN_CTRL  = 4'h0;
    localparam logic [3:0] TGC_OFS_GATE_CTRL  = 4'h1;
    localparam logic [3:0] TGC_OFS_CLK_SEL    = 4'h2;
    localparam logic [3:0] TGC_OFS_GATE_SEL   = 4'h3;

    // Main control fields
    localparam int TGC_MAIN_ON_BIT    = 0;
    localparam int TGC_MAIN_RD16_BIT  = 1;
    localparam int TGC_MAIN_SYNC_BIT  = 2;
    localparam int TGC_MAIN_CKPS_LSB  = 4;
    localparam int TGC_MAIN_CKPS_MSB  = 5;
    localparam logic [7:0] TGC_MAIN_MASK = 8'h37;

    // Gate control fields
    localparam int TGC_GC_ENABLE_BIT  = 7;
    localparam int TGC_GC_POL_BIT     = 6;
    localparam int TGC_GC_TOGGLE_BIT  = 5;
    localparam int TGC_GC_SPM_BIT     = 4;
    localparam int TGC_GC_GO_BIT      = 3;
    localparam int TGC_GC_VAL_BIT     = 2;

    // Select field widths and masks
    localparam int TGC_CS_W  = 4;
    localparam int TGC_GSS_W = 5;
    localparam logic [7:0] TGC_CS_MASK  = 8'h0F;
    localparam logic [7:0] TGC_GSS_MASK = 8'h1F;

    // Reset values
    localparam logic [7:0] TGC_MAIN_RST      = 8'h00;
    localparam logic [3:0] TGC_GATE_CTRL_RST = 4'h0;
    localparam logic [3:0] TGC_CS_RST        = 4'h0;
    localparam logic [4:0] TGC_GSS_RST       = 5'h00;

    // Clock source codes
    localparam logic [3:0] TGC_CS_PIN      = 4'h0;
    localparam logic [3:0] TGC_CS_INSTR    = 4'h1;
    localparam logic [3:0] TGC_CS_SYS      = 4'h2;
    localparam logic [3:0] TGC_CS_HFOSC    = 4'h3;
    localparam logic [3:0] TGC_CS_LFOSC    = 4'h4;
    localparam logic [3:0] TGC_CS_MF500K   = 4'h5;
    localparam logic [3:0] TGC_CS_MF32K    = 4'h6;
    localparam logic [3:0] TGC_CS_SECOSC   = 4'h7;
    localparam logic [3:0] TGC_CS_REFCLK   = 4'h8;
    localparam logic [3:0] TGC_CS_OVF      = 4'h9;
    localparam logic [3:0] TGC_CS_LC1      = 4'hA;
    localparam int         TGC_CS_COUNT    = 14;

    // Gate source codes
    localparam logic [4:0] TGC_GS_PIN      = 5'h00;
    localparam logic [4:0] TGC_GS_OVF      = 5'h01;
    localparam logic [4:0] TGC_GS_SHORT    = 5'h02;
    localparam logic [4:0] TGC_GS_CCP1     = 5'h03;
    localparam logic [4:0] TGC_GS_CCP2     = 5'h04;
    localparam logic [4:0] TGC_GS_PWM3     = 5'h05;
    localparam logic [4:0] TGC_GS_OSC      = 5'h09;
    localparam logic [4:0] TGC_GS_CMP1     = 5'h0A;
    localparam logic [4:0] TGC_GS_CMP2     = 5'h0B;
    localparam logic [4:0] TGC_GS_ZCROSS   = 5'h0C;
    localparam logic [4:0] TGC_GS_LC1      = 5'h0D;
    localparam int         TGC_GS_COUNT    = 17;

    // Single-pulse acquisition states
    typedef enum logic [2:0] {
        TGC_SP_IDLE  = 3'b001,
        TGC_SP_ARMED = 3'b010,
        TGC_SP_RUN   = 3'b100
    } tgc_sp_state_type;

endpackage

// >>> rtl/tgc_src_mux.sv
`timescale 1ns/1ps
`default_nettype none

module tgc_src_mux #(
    parameter int N     = 14,
    parameter int SEL_W = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             clk_en_i,
    input  wire logic [N-1:0]     src_i,
    input  wire logic [SEL_W-1:0] sel_i,
    output logic                  out_o
);

    logic out_next;

    // Codes past the last source give a quiet low level
    always_comb begin
        out_next = 1'b0;
        for (int k = 0; k < N; k++) begin
            if (sel_i == k[SEL_W-1:0]) begin
                out_next = src_i[k];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_o <= 1'b0;
        end else if (clk_en_i) begin
            out_o <= out_next;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/tgc_gate_ctrl.sv
// What this block does
// - Gate enable is ignored while the timer on bit is clear.
// - Gate enable set: count follows gate; clear: count continuously.
// - Polarity 1 counts while gate high, 0 counts while gate low.
// - Toggle mode routes gate through flip-flop; off holds it clear.
// - Toggle flip-flop flips on every rising edge of the gate.
// - Single-pulse mode bit enables or disables single-pulse acquisition.
// - Software sets go bit to arm; hardware clears it when acquisition ends.
// - Clearing single-pulse mode also clears the go bit.
// - Read-only gate value shows gate level regardless of gate enable.
// - Clock codes 0 to 3: pin, instruction, system, high oscillator.
// - Clock codes 4 to 9: low, two medium, secondary, reference, overflow.
// - Gate codes 0 to 4: pin, overflow, short timer, two captures.
// - Unimplemented bits read zero and ignore writes.
// - Controls clear on power reset; gate value resets low, then follows the gate.
// - Clearing timer on stops the timer and clears the gate flip-flop.
// - Armed pulse counts from next rising gate edge, done at trailing edge.
// - Falling edge of gate value raises the gate event flag always.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tgc_gate_ctrl
    import tgc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              clk_en_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    // Clock sources
    input  wire logic              clock_pin_select_input_i,
    input  wire logic              instruction_clock_i,
    input  wire logic              system_clock_i,
    input  wire logic              high_internal_oscillator_i,
    input  wire logic              low_internal_oscillator_i,
    input  wire logic              medium_osc_500k_i,
    input  wire logic              medium_osc_32k_i,
    input  wire logic              secondary_oscillator_i,
    input  wire logic              reference_clock_output_i,
    input  wire logic              other_timer_overflow_i,
    input  wire logic [3:0]        logic_cell_output_i,
    // Gate sources
    input  wire logic              gate_pin_select_input_i,
    input  wire logic              short_timer_postscaled_output_i,
    input  wire logic              capture_compare_one_output_i,
    input  wire logic              capture_compare_two_output_i,
    input  wire logic [3:0]        pulse_width_output_i,
    input  wire logic              oscillator_output_i,
    input  wire logic              comparator_one_synced_i,
    input  wire logic              comparator_two_synced_i,
    input  wire logic              zero_cross_output_i,
    // Results
    output logic                   count_enable_o,
    output logic                   count_tick_o,
    output logic                   gate_value_status_o,
    output logic                   gate_event_flag_o,
    output logic                   timer_on_o
);

    logic [7:0]          main_ctrl_reg;
    logic                gate_enable_reg;
    logic                gate_polarity_reg;
    logic                gate_toggle_mode_reg;
    logic                gate_single_pulse_mode_reg;
    logic [TGC_CS_W-1:0] clk_sel_reg;
    logic [TGC_GSS_W-1:0] gate_sel_reg;
    tgc_sp_state_type    sp_state_reg;
    tgc_sp_state_type    sp_state_next;
    logic                toggle_ff_reg;
    logic                pol_gate_prev_reg;
    logic                path_gate_prev_reg;
    logic                gate_value_status_prev_reg;
    logic                clk_prev_reg;
    logic                gate_value_reg;
    logic                gate_event_reg;
    logic                tick_reg;
    logic                count_en_reg;

    logic [TGC_CS_COUNT-1:0] clk_src;
    logic [TGC_GS_COUNT-1:0] gate_src;
    logic                sel_clk;
    logic                sel_gate;
    logic                pol_gate;
    logic                path_gate;
    logic                spm_gate;
    logic                gate_rise;
    logic                path_rise;
    logic                path_fall;
    logic                timer_on;
    logic                wr_main;
    logic                wr_gc;
    logic                go_bit;
    logic [7:0]          rd_next;

    assign timer_on = main_ctrl_reg[TGC_MAIN_ON_BIT];
    assign wr_main  = wr_i && (addr_i == ADDR_W'(TGC_OFS_MAIN_CTRL));
    assign wr_gc    = wr_i && (addr_i == ADDR_W'(TGC_OFS_GATE_CTRL));
    assign go_bit   = (sp_state_reg != TGC_SP_IDLE);

    // Clock source vector indexed by select code
    assign clk_src = {logic_cell_output_i,
                      other_timer_overflow_i,
                      reference_clock_output_i,
                      secondary_oscillator_i,
                      medium_osc_32k_i,
                      medium_osc_500k_i,
                      low_internal_oscillator_i,
                      high_internal_oscillator_i,
                      system_clock_i,
                      instruction_clock_i,
                      clock_pin_select_input_i};

    // Gate source vector indexed by select code
    assign gate_src = {logic_cell_output_i,
                       zero_cross_output_i,
                       comparator_two_synced_i,
                       comparator_one_synced_i,
                       oscillator_output_i,
                       pulse_width_output_i,
                       capture_compare_two_output_i,
                       capture_compare_one_output_i,
                       short_timer_postscaled_output_i,
                       other_timer_overflow_i,
                       gate_pin_select_input_i};

    tgc_src_mux #(
        .N     (TGC_CS_COUNT),
        .SEL_W (TGC_CS_W)
    ) u_clk_mux (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .clk_en_i  (clk_en_i),
        .src_i     (clk_src),
        .sel_i     (clk_sel_reg),     // Reserved codes give low
        .out_o     (sel_clk)
    );

    tgc_src_mux #(
        .N     (TGC_GS_COUNT),
        .SEL_W (TGC_GSS_W)
    ) u_gate_mux (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .clk_en_i  (clk_en_i),
        .src_i     (gate_src),
        .sel_i     (gate_sel_reg),    // Reserved codes give low
        .out_o     (sel_gate)
    );

    // Gate path, stage by stage
    assign pol_gate  = gate_polarity_reg ? sel_gate : ~sel_gate;
    assign gate_rise = pol_gate && !pol_gate_prev_reg;
    assign path_gate = gate_toggle_mode_reg ? toggle_ff_reg
                                            : pol_gate;
    assign path_rise = path_gate && !path_gate_prev_reg;
    assign path_fall = !path_gate && path_gate_prev_reg;
    assign spm_gate  = (sp_state_reg == TGC_SP_RUN) && path_gate;

    // Main control register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_ctrl_reg <= TGC_MAIN_RST;
        end else if (clk_en_i && wr_main) begin
            main_ctrl_reg <= wdata_i & TGC_MAIN_MASK;
        end
    end

    // Writable gate control bits
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {gate_enable_reg, gate_polarity_reg, gate_toggle_mode_reg,
             gate_single_pulse_mode_reg} <= TGC_GATE_CTRL_RST;
        end else if (clk_en_i && wr_gc) begin
            gate_enable_reg            <= wdata_i[TGC_GC_ENABLE_BIT];
            gate_polarity_reg          <= wdata_i[TGC_GC_POL_BIT];
            gate_toggle_mode_reg       <= wdata_i[TGC_GC_TOGGLE_BIT];
            gate_single_pulse_mode_reg <= wdata_i[TGC_GC_SPM_BIT];
        end
    end

    // Source select registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_sel_reg  <= TGC_CS_RST;
            gate_sel_reg <= TGC_GSS_RST;
        end else if (clk_en_i && wr_i) begin
            if (addr_i == ADDR_W'(TGC_OFS_CLK_SEL)) begin
                clk_sel_reg <= wdata_i[TGC_CS_W-1:0];
            end
            if (addr_i == ADDR_W'(TGC_OFS_GATE_SEL)) begin
                gate_sel_reg <= wdata_i[TGC_GSS_W-1:0];
            end
        end
    end

    // Toggle flip-flop
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            toggle_ff_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (!timer_on) begin
                toggle_ff_reg <= 1'b0;
            end else if (!gate_toggle_mode_reg) begin
                toggle_ff_reg <= 1'b0;
            end else if (gate_rise) begin
                toggle_ff_reg <= ~toggle_ff_reg;
            end
        end
    end

    // Edge history for gate, path and selected clock
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pol_gate_prev_reg  <= 1'b0;
            path_gate_prev_reg <= 1'b0;
            clk_prev_reg       <= 1'b0;
        end else if (clk_en_i) begin
            pol_gate_prev_reg  <= pol_gate;
            path_gate_prev_reg <= path_gate;
            clk_prev_reg       <= sel_clk;
        end
    end

    // Single-pulse acquisition; a software arm wins over completion
    always_comb begin
        sp_state_next = sp_state_reg;
        case (sp_state_reg)
            TGC_SP_IDLE: begin
                sp_state_next = TGC_SP_IDLE;
            end
            TGC_SP_ARMED: begin
                if (path_rise) begin
                    sp_state_next = TGC_SP_RUN;
                end
            end
            TGC_SP_RUN: begin
                if (path_fall) begin
                    sp_state_next = TGC_SP_IDLE;
                end
            end
            default: begin
                sp_state_next = TGC_SP_IDLE;
            end
        endcase
        if (wr_gc) begin
            if (!wdata_i[TGC_GC_GO_BIT]) begin
                sp_state_next = TGC_SP_IDLE;
            end else if (sp_state_reg == TGC_SP_IDLE
                         || sp_state_next == TGC_SP_IDLE) begin
                sp_state_next = TGC_SP_ARMED;
            end
        end
        if ((wr_gc && !wdata_i[TGC_GC_SPM_BIT])
            || (!wr_gc && !gate_single_pulse_mode_reg)) begin
            sp_state_next = TGC_SP_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp_state_reg <= TGC_SP_IDLE;
        end else if (clk_en_i) begin
            sp_state_reg <= sp_state_next;
        end
    end

    // Gate value status and falling-edge event
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gate_value_reg <= 1'b0;
            gate_value_status_prev_reg  <= 1'b0;
            gate_event_reg <= 1'b0;
        end else if (clk_en_i) begin
            gate_value_reg <= gate_single_pulse_mode_reg ? spm_gate
                              : path_gate;
            gate_value_status_prev_reg  <= gate_value_reg;
            gate_event_reg <= gate_value_status_prev_reg && !gate_value_reg;
        end
    end

    // Count enable and count tick
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_en_reg <= 1'b0;
            tick_reg     <= 1'b0;
        end else if (clk_en_i) begin
            if (!timer_on) begin
                count_en_reg <= 1'b0;
            end else if (gate_enable_reg) begin
                count_en_reg <= gate_single_pulse_mode_reg ? spm_gate
                                : path_gate;
            end else begin
                count_en_reg <= 1'b1;
            end
            tick_reg <= count_en_reg && sel_clk && !clk_prev_reg;
        end
    end

    // Register read data, one cycle after the strobe
    always_comb begin
        rd_next = 8'h00;
        case (addr_i)
            ADDR_W'(TGC_OFS_MAIN_CTRL): begin
                rd_next = main_ctrl_reg;
            end
            ADDR_W'(TGC_OFS_GATE_CTRL): begin
                rd_next[TGC_GC_ENABLE_BIT] = gate_enable_reg;
                rd_next[TGC_GC_POL_BIT]    = gate_polarity_reg;
                rd_next[TGC_GC_TOGGLE_BIT] = gate_toggle_mode_reg;
                rd_next[TGC_GC_SPM_BIT]    = gate_single_pulse_mode_reg;
                rd_next[TGC_GC_GO_BIT]     = go_bit;
                rd_next[TGC_GC_VAL_BIT]    = gate_value_reg;
            end
            ADDR_W'(TGC_OFS_CLK_SEL): begin
                rd_next = {4'h0, clk_sel_reg};
            end
            ADDR_W'(TGC_OFS_GATE_SEL): begin
                rd_next = {3'h0, gate_sel_reg};
            end
            default: begin
                rd_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            rdata_o <= rd_i ? rd_next : 8'h00;
        end
    end

    assign count_enable_o      = count_en_reg;
    assign count_tick_o        = tick_reg;
    assign gate_value_status_o = gate_value_reg;
    assign gate_event_flag_o   = gate_event_reg;
    assign timer_on_o          = timer_on;

endmodule

`default_nettype wire

// >>> verification/tgc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module tgc_src_model (
    input  wire logic        ref_clk_i,
    input  wire logic        gate_mode_i,
    input  wire logic        slow_i,
    input  wire logic [16:0] gcmd_i,
    output logic      [13:0] cs_o,
    output logic      [16:0] gs_o
);
    int          cyc      = 0;
    logic [13:0] div_reg  = 14'h0000;
    logic [16:0] gq_reg   = 17'h00000;
    logic [16:0] late_reg = 17'h00000;

    // Source k runs with a period of 2*(k+2) system cycles
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 14; k++) begin
            div_reg[k] <= (cyc / (k + 2)) % 2 == 1;
        end
        late_reg <= gcmd_i;
        gq_reg   <= slow_i ? late_reg : gcmd_i;
    end

    // Overflow and logic-cell lines feed both selectors
    always_comb begin
        cs_o = div_reg;
        gs_o = gq_reg;
        if (gate_mode_i) begin
            cs_o[13:9] = {gq_reg[16:13], gq_reg[1]};
        end else begin
            gs_o[16:13] = div_reg[13:10];
            gs_o[1]     = div_reg[9];
        end
    end
endmodule
`default_nettype wire

// >>> verification/tgc_gate_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tgc_gate_ctrl_chk
    import tgc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic              clk_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              count_enable_o,
    input wire logic              count_tick_o,
    input wire logic              gate_value_status_o,
    input wire logic              gate_event_flag_o,
    input wire logic              timer_on_o
);
    wire logic gc_sel = addr_i == TGC_OFS_GATE_CTRL;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i || !clk_en_i);

    property p_gc_low; rd_i && gc_sel |=> rdata_o[1:0] == 2'h0; endproperty
    a_gc_low: assert property (p_gc_low)
        else $error("gate control unused bits set");
    property p_cs_low;
        rd_i && addr_i == TGC_OFS_CLK_SEL |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_cs_low: assert property (p_cs_low)
        else $error("clock select unused bits set");
    property p_gs_low;
        rd_i && addr_i == TGC_OFS_GATE_SEL |=> rdata_o[7:5] == 3'h0;
    endproperty
    a_gs_low: assert property (p_gs_low)
        else $error("gate select unused bits set");
    property p_gate_value_status_read;
        rd_i && gc_sel
            |=> rdata_o[TGC_GC_VAL_BIT] == $past(gate_value_status_o);
    endproperty
    a_gate_value_status_read: assert property (p_gate_value_status_read)
        else $error("gate value read differs from status");
    property p_off_stop; !timer_on_o [*2] |-> !count_enable_o; endproperty
    a_off_stop: assert property (p_off_stop)
        else $error("count enabled while timer off");
    property p_tick_gated; count_tick_o |-> $past(count_enable_o); endproperty
    a_tick_gated: assert property (p_tick_gated)
        else $error("tick without count enable");
    property p_event;
        $fell(gate_value_status_o) |-> ##[0:2] gate_event_flag_o;
    endproperty
    a_event: assert property (p_event)
        else $error("no gate event after gate value fell");
    property p_spm_clr;
        wr_i && gc_sel && !wdata_i[TGC_GC_SPM_BIT] ##1 rd_i && gc_sel
            |=> !rdata_o[TGC_GC_GO_BIT];
    endproperty
    a_spm_clr: assert property (p_spm_clr)
        else $error("go bit kept after single pulse cleared");

    c_tick: cover property (count_tick_o);
    c_event: cover property (gate_event_flag_o);
    c_count: cover property ($rose(count_enable_o));
endmodule

bind tgc_gate_ctrl tgc_gate_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .count_enable_o(count_enable_o),
    .count_tick_o(count_tick_o), .gate_value_status_o(gate_value_status_o),
    .gate_event_flag_o(gate_event_flag_o), .timer_on_o(timer_on_o)
);
`default_nettype wire

// >>> verification/test_timer1_gate_and_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer1_gate_and_clock_select;
    import tgc_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        clk_en_i  = 1'b1;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        gmode     = 1'b1;
    logic        slow      = 1'b0;
    logic [3:0]  addr_i    = 4'h0;
    logic [7:0]  wdata_i   = 8'h00;
    logic [16:0] gcmd      = 17'h00000;
    wire logic [13:0] cs;
    wire logic [16:0] gs;
    wire logic [7:0]  rdata;
    wire logic        ce, tick, gate_value_status, gev;
    int fails = 0, total_checks = 0, cycles = 0, nev = 0;

    tgc_src_model u_src (.ref_clk_i(ref_clk_i), .gate_mode_i(gmode),
        .slow_i(slow), .gcmd_i(gcmd), .cs_o(cs), .gs_o(gs));
    tgc_gate_ctrl #(.ADDR_W(4)) u_dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata),
        .clock_pin_select_input_i(cs[0]), .instruction_clock_i(cs[1]),
        .system_clock_i(cs[2]), .high_internal_oscillator_i(cs[3]),
        .low_internal_oscillator_i(cs[4]), .medium_osc_500k_i(cs[5]),
        .medium_osc_32k_i(cs[6]), .secondary_oscillator_i(cs[7]),
        .reference_clock_output_i(cs[8]), .other_timer_overflow_i(cs[9]),
        .logic_cell_output_i(cs[13:10]), .gate_pin_select_input_i(gs[0]),
        .short_timer_postscaled_output_i(gs[2]),
        .capture_compare_one_output_i(gs[3]),
        .capture_compare_two_output_i(gs[4]),
        .pulse_width_output_i(gs[8:5]), .oscillator_output_i(gs[9]),
        .comparator_one_synced_i(gs[10]), .comparator_two_synced_i(gs[11]),
        .zero_cross_output_i(gs[12]), .count_enable_o(ce),
        .count_tick_o(tick), .gate_value_status_o(gate_value_status),
        .gate_event_flag_o(gev), .timer_on_o()
    );

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t level %b want %b", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD %0t count %0d want %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        wr_i    <= w;
        rd_i    <= !w;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus(1'b0, a, 8'h00);
        rd_i <= 1'b0;
        #1;
        d = rdata;
        @(posedge ref_clk_i);
    endtask
    // Longer than the worst gate path latency with a slow source
    task automatic settle;
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic gate(input logic lvl);
        gcmd[0] <= lvl;
        settle();
    endtask
    task automatic do_reset;
        rstn_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask
    task automatic regs_zero;
        logic [7:0] d;
        for (int a = 0; a < 5; a++) begin
            rd(4'(a), d);
            chk8(d, (a == 1) ? 8'h04 : 8'h00);
        end
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (gev === 1'b1) nev++;
        if (cycles == 6000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        logic [7:0] d;
        logic       e, pv;
        int         r, t;
        logic [7:0] msk [5] = '{8'h37, 8'hF8, 8'h0F, 8'h1F, 8'h00};
        void'($urandom(23570));
        do_reset();
        regs_zero();
        for (int a = 0; a < 5; a++) begin
            wr(4'(a), 8'hFF);
            rd(4'(a), d);
            chk8(d, msk[a]);
        end
        bus(1'b1, TGC_OFS_GATE_CTRL, 8'hC8);
        rd(TGC_OFS_GATE_CTRL, d);
        chk8(d, 8'hC0);
        wr(TGC_OFS_MAIN_CTRL, 8'h01);
        // Each of the 17 gate source codes in both polarities, no reserved codes
        for (int p = 0; p < 2; p++) begin
            slow <= p[0];
            wr(TGC_OFS_GATE_CTRL, {1'b1, p[0], 6'h00});
            for (int c = 0; c < 17; c++) begin
                wr(TGC_OFS_GATE_SEL, 8'(c));
                gcmd <= 17'($urandom);
                settle();
                e = gcmd[c];
                chk1(gate_value_status, e ^ !p[0]);
                chk1(ce, e ^ !p[0]);
            end
        end
        gcmd <= 17'h00000;
        wr(TGC_OFS_GATE_SEL, 8'h00);
        wr(TGC_OFS_GATE_CTRL, 8'h40);
        settle();
        chk1(ce, 1'b1);
        wr(TGC_OFS_MAIN_CTRL, 8'h00);
        settle();
        chk1(ce, 1'b0);
        wr(TGC_OFS_GATE_CTRL, 8'hC0);
        gate(1'b1);
        chk1(ce, 1'b0);
        wr(TGC_OFS_MAIN_CTRL, 8'h01);
        wr(TGC_OFS_GATE_CTRL, 8'h40);
        t = nev;
        gate(1'b0);
        chkn(nev - t, 1, 1);
        wr(TGC_OFS_GATE_CTRL, 8'hE0);
        for (int i = 1; i < 4; i++) begin
            gate(1'b1);
            gate(1'b0);
            chk1(ce, 1'(i % 2));
        end
        wr(TGC_OFS_MAIN_CTRL, 8'h00);
        wr(TGC_OFS_MAIN_CTRL, 8'h01);
        settle();
        chk1(ce, 1'b0);
        gate(1'b1);
        gate(1'b0);
        wr(TGC_OFS_GATE_CTRL, 8'hC0);
        wr(TGC_OFS_GATE_CTRL, 8'hE0);
        settle();
        chk1(ce, 1'b0);
        wr(TGC_OFS_GATE_CTRL, 8'hD8);
        rd(TGC_OFS_GATE_CTRL, d);
        chk8(d, 8'hD8);
        gate(1'b1);
        chk1(ce, 1'b1);
        gate(1'b0);
        rd(TGC_OFS_GATE_CTRL, d);
        chk8(d, 8'hD0);
        gate(1'b1);
        chk1(ce, 1'b0);
        wr(TGC_OFS_GATE_CTRL, 8'hC0);
        settle();
        chk1(ce, 1'b1);
        gate(1'b0);
        // Free running: ticks follow rising edges of the chosen clock
        gmode <= 1'b0;
        wr(TGC_OFS_GATE_CTRL, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr(TGC_OFS_CLK_SEL, 8'(c));
            settle();
            r = 0;
            t = 0;
            pv = cs[c % 14];
            for (int i = 0; i < 92; i++) begin
                @(posedge ref_clk_i);
                #1;
                if (i < 90 && c < 14 && cs[c % 14] && !pv) r++;
                if (i >= 2 && tick === 1'b1) t++;
                pv = cs[c % 14];
            end
            if (c < 14) chkn(t, r - 1, r + 1);
            else chkn(t, 0, 0);
        end
        for (int a = 0; a < 4; a++) wr(4'(a), 8'hFF);
        do_reset();
        regs_zero();
        print_verdict();
    end
endmodule
`default_nettype wire
